// *** cat_pkg.sv ***
package cat_pkg;

    // ----------------------------------------
    // register map (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] CAT_OFF_COUNT_LOW  = 8'h00;
    localparam logic [7:0] CAT_OFF_COUNT_HIGH = 8'h04;
    localparam logic [7:0] CAT_OFF_MODE       = 8'h08;
    localparam logic [7:0] CAT_OFF_IRQ_EN     = 8'h0C;
    localparam logic [7:0] CAT_OFF_MOD_CTRL   = 8'h10;
    localparam logic [7:0] CAT_OFF_MOD_CMP    = 8'h28;

    // ----------------------------------------
    // counter mode register fields
    // ----------------------------------------
    localparam int CAT_MODE_ECF_BIT  = 0;
    localparam int CAT_MODE_SEL_LSB  = 1;
    localparam int CAT_MODE_WDOG_BIT = 6;
    localparam int CAT_MODE_IDLE_BIT = 7;
    localparam int CAT_MODE_FLAG_BIT = 8;
    localparam logic [7:0] CAT_MODE_RESET = 8'h40;

    // irq enable register fields
    localparam int CAT_IRQ_GLOBAL_BIT = 0;
    localparam int CAT_IRQ_ARRAY_BIT  = 1;

    // module control fields
    localparam int CAT_MC_MODE_LSB = 0;
    localparam int CAT_MC_EN_BIT   = 3;

    // ----------------------------------------
    // timebase selections and dividers
    // ----------------------------------------
    typedef enum logic [2:0] {
        CAT_TB_DIV12  = 3'h0,
        CAT_TB_DIV4   = 3'h1,
        CAT_TB_T0OVF  = 3'h2,
        CAT_TB_EXTIN  = 3'h3,
        CAT_TB_SYS    = 3'h4,
        CAT_TB_XOSC8  = 3'h5,
        CAT_TB_RTC8   = 3'h6
    } cat_timebase_t;

    typedef enum logic [2:0] {
        CAT_CM_CAPTURE = 3'h0,
        CAT_CM_SWTIMER = 3'h1,
        CAT_CM_HSOUT   = 3'h2,
        CAT_CM_FREQOUT = 3'h3,
        CAT_CM_PWM8    = 3'h4,
        CAT_CM_PWM16   = 3'h5
    } cat_modmode_t;

    localparam int CAT_DIV12 = 12;
    localparam int CAT_DIV4  = 4;
    localparam int CAT_OSC_DIV = 8;
    localparam int CAT_NUM_MODULES = 6;
    localparam int CAT_WDOG_MODULE = 5;

endpackage

// *** cat_counter_array.sv ***
`timescale 1ns/1ps
module cat_counter_array
    import cat_pkg::*;
#(
    parameter int NUM_MODULES = CAT_NUM_MODULES
) (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // count sources
    input  wire logic        timer0Overflow,
    input  wire logic        externalCountInput,
    input  wire logic        oscDiv8,
    input  wire logic        rtcDiv8,
    input  wire logic        cpuIdle,
    // module io lines and irq
    input  wire logic [5:0]  moduleIoIn,
    output logic [5:0]       moduleIoLine,
    output logic             overflowIrq
);

    // only six module slots are decoded in the register map
    if (NUM_MODULES != CAT_NUM_MODULES) begin : g_bad_modules
        $error("cat_counter_array supports six modules only");
    end

    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    logic [2:0] syncA;
    logic [2:0] syncB;
    logic [2:0] syncC;
    logic [5:0] ioA;
    logic [5:0] ioB;
    logic [5:0] ioC;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            syncA <= 3'h0;
            syncB <= 3'h0;
            syncC <= 3'h0;
            ioA   <= 6'h00;
            ioB   <= 6'h00;
            ioC   <= 6'h00;
        end else begin
            syncA <= {rtcDiv8, oscDiv8, externalCountInput};
            syncB <= syncA;
            syncC <= syncB;
            ioA   <= moduleIoIn;
            ioB   <= ioA;
            ioC   <= ioB;
        end
    end

    // ----------------------------------------
    // prescaler
    // ----------------------------------------
    logic [3:0] div12Cnt;
    logic [1:0] div4Cnt;
    logic [3:0] next_div12Cnt;
    logic [1:0] next_div4Cnt;

    always_comb begin
        next_div12Cnt = (div12Cnt == 4'(CAT_DIV12 - 1)) ? 4'h0
                                                       : div12Cnt + 4'h1;
        next_div4Cnt  = div4Cnt + 2'h1;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            div12Cnt <= 4'h0;
            div4Cnt  <= 2'h0;
        end else begin
            div12Cnt <= next_div12Cnt;
            div4Cnt  <= next_div4Cnt;
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [15:0] count;
    logic [7:0]  snapHigh;
    logic [7:0]  modeReg;
    logic        ovfFlag;
    logic [1:0]  irqEn;
    logic [3:0]  modCtrl [6];
    logic [15:0] modCmp  [6];
    logic [5:0]  ioOut;
    logic [5:0]  modFlag;

    logic [15:0] next_count;
    logic [7:0]  next_snapHigh;
    logic [7:0]  next_modeReg;
    logic        next_ovfFlag;
    logic [1:0]  next_irqEn;
    logic [3:0]  next_modCtrl [6];
    logic [15:0] next_modCmp  [6];
    logic [5:0]  next_ioOut;
    logic [5:0]  next_modFlag;
    logic [31:0] next_prdata;
    logic        next_pready;
    logic        next_pslverr;
    logic        next_irq;

    logic        tick;
    logic        wrEn;
    logic        rdEn;
    logic        wdog;
    logic [2:0]  sel;
    logic [2:0]  mIdx;
    logic        mapped;
    logic [2:0]  cm;
    logic [5:0]  modSet;

    function automatic logic [2:0] modIndex(input logic [7:0] a,
                                            input logic [7:0] base);
        logic [7:0] d;
        d = (a - base) >> 2;
        return d[2:0];
    endfunction

    // shared by software timer, high-speed output and watchdog
    function automatic logic cmpHit(input logic        t,
                                    input logic [15:0] c,
                                    input logic [15:0] m);
        return t && (c == m);
    endfunction

    always_comb begin
        sel  = modeReg[CAT_MODE_SEL_LSB +: 3];
        wdog = modeReg[CAT_MODE_WDOG_BIT];
        // misaligned writes must not land in a neighbour
        wrEn = psel && penable && pwrite && !pready
               && (paddr[1:0] == 2'h0);
        rdEn = psel && penable && !pwrite && !pready;
        case (sel)
            CAT_TB_DIV12: tick = (div12Cnt == 4'h0);
            CAT_TB_DIV4:  tick = (div4Cnt == 2'h0);
            CAT_TB_T0OVF: tick = timer0Overflow;
            CAT_TB_EXTIN: tick = syncC[0] && !syncB[0];
            CAT_TB_SYS:   tick = 1'b1;
            CAT_TB_XOSC8: tick = !syncC[1] && syncB[1];
            CAT_TB_RTC8:  tick = !syncC[2] && syncB[2];
            default:      tick = 1'b0;
        endcase
        if (modeReg[CAT_MODE_IDLE_BIT] && cpuIdle) begin
            tick = 1'b0;
        end
        next_count = tick ? count + 16'h0001 : count;
        next_ovfFlag = ovfFlag;
        next_snapHigh = snapHigh;
        next_modeReg = modeReg;
        next_irqEn = irqEn;
        next_modCtrl = modCtrl;
        next_modCmp = modCmp;
        next_ioOut = ioOut;
        next_modFlag = modFlag;
        next_prdata = prdata;
        next_pslverr = 1'b0;
        next_pready = psel && penable && !pready;
        mapped = 1'b1;
        mIdx = 3'h0;
        modSet = 6'h00;
        cm = 3'h0;
        if (paddr >= CAT_OFF_MOD_CMP) begin
            mIdx = modIndex(paddr, CAT_OFF_MOD_CMP);
        end else if (paddr >= CAT_OFF_MOD_CTRL) begin
            mIdx = modIndex(paddr, CAT_OFF_MOD_CTRL);
        end
        for (int i = 0; i < 6; i++) begin
            cm = modCtrl[i][CAT_MC_MODE_LSB +: 3];
            if (modCtrl[i][CAT_MC_EN_BIT]) begin
                case (cm)
                    CAT_CM_CAPTURE: if (ioC[i] != ioB[i]) begin
                        next_modCmp[i] = count;
                        modSet[i] = 1'b1;
                    end
                    CAT_CM_SWTIMER: if (cmpHit(tick, count, modCmp[i])) begin
                        modSet[i] = 1'b1;
                    end
                    CAT_CM_HSOUT: if (cmpHit(tick, count, modCmp[i])) begin
                        next_ioOut[i] = !ioOut[i];
                        modSet[i] = 1'b1;
                    end
                    CAT_CM_FREQOUT:
                        if (tick && count[7:0] == modCmp[i][7:0]) begin
                            next_ioOut[i] = !ioOut[i];
                            next_modCmp[i][7:0] = modCmp[i][7:0]
                                                  + modCmp[i][15:8];
                        end
                    CAT_CM_PWM8:
                        next_ioOut[i] = (count[7:0] >= modCmp[i][15:8]);
                    CAT_CM_PWM16:
                        next_ioOut[i] = (count >= modCmp[i]);
                    default: next_ioOut[i] = ioOut[i];
                endcase
            end
        end
        // watchdog expiry holds flag on module 5
        if (wdog && cmpHit(tick, count, modCmp[CAT_WDOG_MODULE])) begin
            modSet[CAT_WDOG_MODULE] = 1'b1;
        end
        if (wrEn) begin
            case (paddr)
                CAT_OFF_COUNT_LOW:  next_count[7:0]  = pwdata[7:0];
                CAT_OFF_COUNT_HIGH: next_count[15:8] = pwdata[7:0];
                CAT_OFF_MODE: begin
                    if (!wdog || !pwdata[CAT_MODE_WDOG_BIT]) begin
                        next_modeReg = pwdata[7:0];
                    end
                    if (!pwdata[CAT_MODE_FLAG_BIT]) begin
                        next_ovfFlag = 1'b0;
                    end
                end
                CAT_OFF_IRQ_EN: next_irqEn = pwdata[1:0];
                default: begin
                    if (paddr >= CAT_OFF_MOD_CMP && mIdx < 3'h6) begin
                        next_modCmp[mIdx] = pwdata[15:0];
                    end else if (paddr >= CAT_OFF_MOD_CTRL
                                 && mIdx < 3'h6) begin
                        next_modCtrl[mIdx] = pwdata[3:0];
                        next_modFlag[mIdx] = pwdata[4] & modFlag[mIdx];
                    end else begin
                        mapped = 1'b0;
                    end
                end
            endcase
        end
        // hardware set beats a software clear in the same cycle
        next_modFlag = next_modFlag | modSet;
        if (rdEn) begin
            case (paddr)
                CAT_OFF_COUNT_LOW: begin
                    next_prdata = {24'h0, count[7:0]};
                    next_snapHigh = count[15:8];
                end
                CAT_OFF_COUNT_HIGH: next_prdata = {24'h0, snapHigh};
                CAT_OFF_MODE:
                    next_prdata = {23'h0, ovfFlag, modeReg};
                CAT_OFF_IRQ_EN: next_prdata = {30'h0, irqEn};
                default: begin
                    if (paddr >= CAT_OFF_MOD_CMP && mIdx < 3'h6) begin
                        next_prdata = {16'h0, modCmp[mIdx]};
                    end else if (paddr >= CAT_OFF_MOD_CTRL
                                 && mIdx < 3'h6) begin
                        next_prdata = {27'h0, modFlag[mIdx],
                                       modCtrl[mIdx]};
                    end else begin
                        mapped = 1'b0;
                        next_prdata = 32'h0;
                    end
                end
            endcase
        end
        if ((paddr[1:0] != 2'h0)
            || (paddr >= CAT_OFF_MOD_CMP + 8'h18)) begin
            mapped = 1'b0;
        end
        // refused reads return zero, never stale data
        if (rdEn && !mapped) begin
            next_prdata = 32'h0;
        end
        next_pslverr = next_pready && !mapped;
        // wrap sets flag, set beats clear
        if (tick && count == 16'hFFFF) begin
            next_ovfFlag = 1'b1;
        end
        next_irq = ovfFlag && modeReg[CAT_MODE_ECF_BIT]
                   && irqEn[CAT_IRQ_GLOBAL_BIT] && irqEn[CAT_IRQ_ARRAY_BIT];
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            count       <= 16'h0000;
            snapHigh    <= 8'h00;
            modeReg     <= CAT_MODE_RESET;
            ovfFlag     <= 1'b0;
            irqEn       <= 2'h0;
            modCtrl     <= '{default: 4'h0};
            modCmp      <= '{default: 16'hFFFF};
            ioOut       <= 6'h3F;
            modFlag     <= 6'h00;
            prdata      <= 32'h0000_0000;
            pready      <= 1'b0;
            pslverr     <= 1'b0;
            overflowIrq <= 1'b0;
        end else begin
            count       <= next_count;
            snapHigh    <= next_snapHigh;
            modeReg     <= next_modeReg;
            ovfFlag     <= next_ovfFlag;
            irqEn       <= next_irqEn;
            modCtrl     <= next_modCtrl;
            modCmp      <= next_modCmp;
            ioOut       <= next_ioOut;
            modFlag     <= next_modFlag;
            prdata      <= next_prdata;
            pready      <= next_pready;
            pslverr     <= next_pslverr;
            overflowIrq <= next_irq;
        end
    end

    assign moduleIoLine = ioOut;

endmodule // cat_counter_array

// *** cat_counter_array_properties.sv ***
`timescale 1ns/1ps
module cat_counter_array_properties
    import cat_pkg::*;
#(
    parameter int NUM_MODULES = CAT_NUM_MODULES
) (
    // clock and reset
    input wire logic        ref_clk,
    input wire logic        rst_n,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    // sources and outputs
    input wire logic        timer0Overflow,
    input wire logic        externalCountInput,
    input wire logic        oscDiv8,
    input wire logic        rtcDiv8,
    input wire logic        cpuIdle,
    input wire logic [5:0]  moduleIoIn,
    input wire logic [5:0]  moduleIoLine,
    input wire logic        overflowIrq
);
    logic accessWait;
    logic unmapped;
    assign accessWait = psel && penable && !pready;
    // beyond 0x3C every access is refused, but aligned writes there can still alias into modCmp
    assign unmapped = (paddr[1:0] != 2'h0) || (paddr > 8'h3C);

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // ----------------------------------------
    // properties
    // ----------------------------------------
    a_ready_one_wait: assert property ($rose(penable) && psel |=> pready)
        else $error("pready late");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready wider than one cycle");
    a_ready_cause: assert property (pready |-> $past(accessWait))
        else $error("pready without access");
    a_err_unmapped: assert property (accessWait && unmapped |=> pslverr)
        else $error("unmapped access not refused");
    a_err_mapped: assert property (accessWait && !unmapped |=> !pslverr)
        else $error("mapped access refused");
    a_read_err_zero: assert property (pready && pslverr && !pwrite
        |-> prdata == 32'h0) else $error("refused read data not zero");
    a_rdata_holds: assert property ($changed(prdata) |-> pready && !pwrite)
        else $error("read data moved outside a read");
    a_irq_held: assert property ($fell(overflowIrq) |->
        $past(pready && pwrite) || $past(pready && pwrite, 2)
        || $past(pready && pwrite, 3)) else $error("irq dropped alone");
    a_io_reset: assert property ($rose(rst_n)
        |-> moduleIoLine == 6'h3F && !overflowIrq)
        else $error("outputs not at reset level");

    c_irq: cover property ($rose(overflowIrq));
    c_refused: cover property (pready && pslverr);
    c_high_read: cover property (pready && !pwrite
        && paddr == CAT_OFF_COUNT_HIGH);
endmodule // cat_counter_array_properties

bind cat_counter_array cat_counter_array_properties #(
    .NUM_MODULES(NUM_MODULES)
) u_props (.*);

// *** cat_src_model.sv ***
`timescale 1ns/1ps
module cat_src_model (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // count sources
    output logic     timer0Overflow,
    output logic     externalCountInput,
    output logic     oscDiv8,
    output logic     rtcDiv8
);
    // wide enough never to wrap in one run, so periods stay exact
    logic [31:0] tick;
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            tick <= 32'h0;
        end else begin
            tick <= tick + 32'h1;
        end
    end
    assign timer0Overflow = (tick % 6) == 0;
    assign externalCountInput = (tick % 8) < 4;
    assign oscDiv8 = (tick % 10) < 5;
    assign rtcDiv8 = (tick % 14) < 7;
endmodule // cat_src_model

// *** cat_counter_array_tb_top.sv ***
`timescale 1ns/1ps
`define CHK(nm, e, g) chk(nm, 32'(e), 32'(g))
module cat_counter_array_tb_top
    import cat_pkg::*;
;
    logic        ref_clk;
    logic        rst_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic        t0Ovf;
    logic        extIn;
    logic        osc;
    logic        rtc;
    logic        cpuIdle;
    logic [5:0]  ioIn;
    logic [5:0]  ioLine;
    logic        irq;
    logic [31:0] rdat;
    logic        rerr;
    int          tStamp;
    int          cycle = 0;
    int          errorCnt;
    int          numChecks;

    cat_counter_array DUT (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .timer0Overflow(t0Ovf), .externalCountInput(extIn),
        .oscDiv8(osc), .rtcDiv8(rtc), .cpuIdle(cpuIdle),
        .moduleIoIn(ioIn), .moduleIoLine(ioLine), .overflowIrq(irq));
    cat_src_model u_src (.ref_clk(ref_clk), .rst_n(rst_n),
        .timer0Overflow(t0Ovf), .externalCountInput(extIn),
        .oscDiv8(osc), .rtcDiv8(rtc));

    // ----------------------------------------
    // clock, timeout, report
    // ----------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cycle <= cycle + 1;
        if (cycle == 4000) begin
            errorCnt++;
            report_and_stop;
        end
    end
    task report_and_stop;
        $display("checks %0d errors %0d", numChecks, errorCnt);
        if (errorCnt == 0 && numChecks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    function automatic void chk(string nm, logic [31:0] e, logic [31:0] g);
        numChecks++;
        if (g !== e) begin
            errorCnt++;
            $display("wrong value %s exp %h got %h", nm, e, g);
        end
    endfunction

    // ----------------------------------------
    // bus helpers
    // ----------------------------------------
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        // latency checked as two waits; the bench timeout ends a hang
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1);
        `CHK("pready wait", 2, n);
        rdat = prdata;
        rerr = pslverr;
        tStamp = cycle;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic mode(input logic [2:0] sel, input logic stop,
                        input logic ecf);
        // bit8 written as one keeps the flag
        apb(1'b1, CAT_OFF_MODE, {23'h0, 1'b1, stop, 3'h0, sel, ecf});
    endtask
    // ticks between two low reads; per 0 means stopped
    task automatic t_rate(input logic [2:0] sel, input logic stop,
                          input logic idle, input int per);
        int c1;
        logic [7:0] l1;
        logic [7:0] d;
        logic [7:0] e;
        cpuIdle <= idle;
        mode(sel, stop, 1'b0);
        apb(1'b0, CAT_OFF_COUNT_LOW, 32'h0);
        l1 = rdat[7:0];
        c1 = tStamp;
        repeat (40) @(posedge ref_clk);
        apb(1'b0, CAT_OFF_COUNT_LOW, 32'h0);
        d = rdat[7:0] - l1;
        e = (per == 0) ? 8'h00 : 8'((tStamp - c1) / per);
        `CHK("rate", 1'b1, (d === e) || (per > 1 && d === e + 8'h01));
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset;
        `CHK("ioLine", 6'h3F, ioLine);
        apb(1'b0, CAT_OFF_MODE, 32'h0);
        `CHK("mode reset", CAT_MODE_RESET, rdat[8:0]);
        apb(1'b1, CAT_OFF_MODE, 32'h0000_0148);
        apb(1'b0, CAT_OFF_MODE, 32'h0);
        `CHK("guarded mode", CAT_MODE_RESET, rdat[8:0]);
        apb(1'b0, CAT_OFF_IRQ_EN, 32'h0);
        `CHK("irq en reset", 2'h0, rdat[1:0]);
        apb(1'b0, 8'h40, 32'h0);
        `CHK("unmapped err", 1'b1, rerr);
        `CHK("unmapped data", 32'h0, rdat);
        apb(1'b1, 8'h02, 32'h0);
        `CHK("unaligned", 1'b1, rerr);
    endtask
    task automatic t_timebase;
        t_rate(CAT_TB_SYS, 1'b0, 1'b0, 1);
        t_rate(CAT_TB_DIV4, 1'b0, 1'b0, 4);
        t_rate(CAT_TB_DIV12, 1'b0, 1'b0, 12);
        t_rate(CAT_TB_T0OVF, 1'b0, 1'b0, 6);
        t_rate(CAT_TB_EXTIN, 1'b0, 1'b0, 8);
        t_rate(CAT_TB_XOSC8, 1'b0, 1'b0, 10);
        t_rate(CAT_TB_RTC8, 1'b0, 1'b0, 14);
    endtask
    task automatic t_idle;
        t_rate(CAT_TB_SYS, 1'b0, 1'b1, 1);
        t_rate(CAT_TB_SYS, 1'b1, 1'b1, 0);
        t_rate(CAT_TB_SYS, 1'b1, 1'b0, 1);
    endtask
    task automatic t_snapshot;
        logic [7:0] l;
        mode(CAT_TB_SYS, 1'b0, 1'b0);
        apb(1'b1, CAT_OFF_COUNT_LOW, 32'h0);
        apb(1'b1, CAT_OFF_COUNT_HIGH, 32'h12);
        apb(1'b1, CAT_OFF_COUNT_LOW, 32'hF8);
        apb(1'b0, CAT_OFF_COUNT_LOW, 32'h0);
        l = rdat[7:0];
        repeat (20) @(posedge ref_clk);
        apb(1'b0, CAT_OFF_COUNT_HIGH, 32'h0);
        `CHK("snapshot", (l >= 8'hF8) ? 8'h12 : 8'h13, rdat[7:0]);
        apb(1'b0, CAT_OFF_COUNT_LOW, 32'h0);
        apb(1'b0, CAT_OFF_COUNT_HIGH, 32'h0);
        `CHK("high after wrap", 8'h13, rdat[7:0]);
    endtask
    task automatic t_overflow;
        mode(CAT_TB_SYS, 1'b0, 1'b1);
        apb(1'b1, CAT_OFF_IRQ_EN, 32'h3);
        apb(1'b1, CAT_OFF_COUNT_LOW, 32'h0);
        apb(1'b1, CAT_OFF_COUNT_HIGH, 32'hFF);
        apb(1'b1, CAT_OFF_COUNT_LOW, 32'hF0);
        `CHK("irq before wrap", 1'b0, irq);
        repeat (30) @(posedge ref_clk);
        `CHK("irq", 1'b1, irq);
        apb(1'b0, CAT_OFF_MODE, 32'h0);
        `CHK("flag", 1'b1, rdat[CAT_MODE_FLAG_BIT]);
        apb(1'b1, CAT_OFF_IRQ_EN, 32'h1);
        repeat (3) @(posedge ref_clk);
        `CHK("irq array off", 1'b0, irq);
        apb(1'b1, CAT_OFF_IRQ_EN, 32'h2);
        repeat (3) @(posedge ref_clk);
        `CHK("irq global off", 1'b0, irq);
        apb(1'b1, CAT_OFF_IRQ_EN, 32'h3);
        repeat (3) @(posedge ref_clk);
        `CHK("irq both on", 1'b1, irq);
        mode(CAT_TB_SYS, 1'b0, 1'b0);
        repeat (50) @(posedge ref_clk);
        `CHK("irq ecf off", 1'b0, irq);
        apb(1'b0, CAT_OFF_MODE, 32'h0);
        `CHK("flag kept", 1'b1, rdat[CAT_MODE_FLAG_BIT]);
        apb(1'b1, CAT_OFF_MODE, 32'h0000_0009);
        apb(1'b0, CAT_OFF_MODE, 32'h0);
        `CHK("flag cleared", 1'b0, rdat[CAT_MODE_FLAG_BIT]);
        `CHK("irq cleared", 1'b0, irq);
    endtask
    task automatic t_modules;
        apb(1'b1, CAT_OFF_MOD_CTRL, 32'h0000_000D);
        repeat (3) @(posedge ref_clk);
        `CHK("pwm16 low", 1'b0, ioLine[0]);
        apb(1'b1, CAT_OFF_MOD_CMP + 8'h04, 32'h0000_5040);
        apb(1'b1, CAT_OFF_COUNT_LOW, 32'h0);
        apb(1'b1, CAT_OFF_COUNT_HIGH, 32'h50);
        apb(1'b1, CAT_OFF_MOD_CTRL + 8'h04, 32'h0000_0009);
        apb(1'b0, CAT_OFF_MOD_CTRL + 8'h04, 32'h0);
        `CHK("timer early", 5'h09, rdat[4:0]);
        repeat (70) @(posedge ref_clk);
        apb(1'b0, CAT_OFF_MOD_CTRL + 8'h04, 32'h0);
        `CHK("timer match", 5'h19, rdat[4:0]);
        apb(1'b1, CAT_OFF_MOD_CTRL + 8'h08, 32'h0000_0008);
        ioIn <= 6'h04;
        repeat (5) @(posedge ref_clk);
        apb(1'b0, CAT_OFF_MOD_CMP + 8'h08, 32'h0);
        `CHK("capture high", 8'h50, rdat[15:8]);
        apb(1'b0, CAT_OFF_MOD_CTRL + 8'h08, 32'h0);
        `CHK("capture flag", 5'h18, rdat[4:0]);
    endtask

    initial begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        cpuIdle = 1'b0;
        ioIn = 6'h00;
        errorCnt = 0;
        numChecks = 0;
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_reset;
        t_timebase;
        t_idle;
        t_snapshot;
        t_overflow;
        t_modules;
        report_and_stop;
    end
endmodule // cat_counter_array_tb_top
